// File: verilog/scpt_cfg.svh
// Register offsets, field positions, reset values and counts of the split capture/PWM timer
`ifndef SCPT_CFG_SVH
`define SCPT_CFG_SVH
`define SCPT_ADDR_W 8
`define SCPT_OFF_CTRL 8'h00
`define SCPT_OFF_MODE 8'h04
`define SCPT_OFF_MODE1 8'h08
`define SCPT_OFF_COUNT 8'h0c
`define SCPT_OFF_RELOAD 8'h10
`define SCPT_RST_BYTE 8'h00
`define SCPT_RST_NIBBLE 4'h0
`define SCPT_PRESCALE_LAST 4'hb
`define SCPT_C_OVF 7
`define SCPT_C_EXT 6
`define SCPT_C_B5 5
`define SCPT_C_B4 4
`define SCPT_C_NEG 3
`define SCPT_C_RUN 2
`define SCPT_C_CT 1
`define SCPT_C_CPRL 0
`define SCPT_M_SPLIT 7
`define SCPT_M_LCLO 6
`define SCPT_M_POS 5
`define SCPT_M_X12 4
`define SCPT_M_LRUN 3
`define SCPT_M_LCLR 2
`define SCPT_M_OE 1
`define SCPT_M_MS0 0
`define SCPT_M1_LCHI 7
`define SCPT_M1_IGN 6
`define SCPT_M1_ACC 5
`define SCPT_M1_CKS 4
`define SCPT_M1_MS1 3
`define SCPT_M1_SRC_HI 2
`define SCPT_RESP_OKAY 2'b00
`define SCPT_RESP_SLVERR 2'b10
`endif

// File: verilog/scpt_pkg.sv
// Shared types of the split capture/PWM timer
`include "scpt_cfg.svh"
package scpt_pkg;
	typedef enum logic [2:0] {
		SCPT_RELOAD = 3'b000,
		SCPT_RELOAD_EXT = 3'b001,
		SCPT_CAPTURE = 3'b010,
		SCPT_CAPTURE_ZERO = 3'b011,
		SCPT_PWM = 3'b100
	} scpt_mode_e;
	typedef struct packed {
		logic awvalid;
		logic [`SCPT_ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [`SCPT_ADDR_W-1:0] araddr;
		logic rready;
	} scpt_axi_req_s;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} scpt_axi_rsp_s;
	typedef struct packed {
		logic int1Event;
		logic baudOvf;
		logic t0Ovf;
		logic ac1Event;
		logic t1Ovf;
	} scpt_src_s;
endpackage

// File: verilog/scpt_sync_edge.sv
// Two-stage synchroniser with registered rise and fall detection
`timescale 1ns/1ps
`default_nettype none
module scpt_sync_edge #(
	parameter int W = 9
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [W-1:0] asyncIn,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	logic [W-1:0] stage1_reg;
	logic [W-1:0] stage2_reg;
	logic [W-1:0] last_reg;
	logic [2:0] warm_reg;
	// Edges are held off until the delay line holds real pin samples, so reset gives no false edge
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			stage1_reg <= '0;
			stage2_reg <= '0;
			last_reg <= '0;
			warm_reg <= 3'h0;
			rise <= '0;
			fall <= '0;
		end else begin
			stage1_reg <= asyncIn;
			stage2_reg <= stage1_reg;
			last_reg <= stage2_reg;
			warm_reg <= {warm_reg[1:0], 1'b1};
			rise <= stage2_reg & ~last_reg & {W{warm_reg[2]}};
			fall <= ~stage2_reg & last_reg & {W{warm_reg[2]}};
		end
	end
endmodule
`default_nettype wire

// File: verilog/scpt_timer.sv
// Split capture/PWM timer with AXI4-Lite register access
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "scpt_cfg.svh"
module scpt_timer (
	input wire logic clk_sys,
	input wire logic rst,
	input wire scpt_pkg::scpt_axi_req_s axiReq,
	output var scpt_pkg::scpt_axi_rsp_s axiRsp,
	input wire logic countPin,
	input wire logic [7:0] captureIn,
	input wire scpt_pkg::scpt_src_s srcEvents,
	output logic clockOutPin,
	output logic clockOutOe,
	output logic wideOverflowEvent,
	output logic timerIrq,
	output logic rxBaudSelect,
	output logic txBaudSelect
);
	import scpt_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Registers
	logic bvalid_reg, rvalid_reg, ovfFlag_reg, extFlag_reg, lowFlag_reg;
	logic lowIe_reg, rxSel_reg, txSel_reg, clkTog_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;
	logic [3:0] ctrlCfg_reg, div12_reg;
	logic [7:0] modeCfg_reg, mode1Cfg_reg, countLow_reg, countHigh_reg, reloadLow_reg, reloadHigh_reg;
	logic [7:0] loNext, hiNext, rlNext, rhNext;
	scpt_mode_e modeSel;

	////////////////////////////////////////////////////////////////////////////
	// Bus decode
	wire wrFire = axiReq.awvalid & axiReq.wvalid & ~bvalid_reg;
	wire rdFire = axiReq.arvalid & ~rvalid_reg;
	wire [5:0] wrWord = axiReq.awaddr[7:2];
	wire [5:0] rdWord = axiReq.araddr[7:2];
	wire wHitCtrl = wrWord == `SCPT_OFF_CTRL >> 2;
	wire wHitMode = wrWord == `SCPT_OFF_MODE >> 2;
	wire wHitMode1 = wrWord == `SCPT_OFF_MODE1 >> 2;
	wire wHitCount = wrWord == `SCPT_OFF_COUNT >> 2;
	wire wHitReload = wrWord == `SCPT_OFF_RELOAD >> 2;
	wire wMapped = wHitCtrl | wHitMode | wHitMode1 | wHitCount | wHitReload;
	wire [31:0] wd = axiReq.wdata;
	wire ctrlWr = wrFire & wHitCtrl & axiReq.wstrb[0];
	wire modeWr = wrFire & wHitMode & axiReq.wstrb[0];
	wire mode1Wr = wrFire & wHitMode1 & axiReq.wstrb[0];
	wire cntWrLo = wrFire & wHitCount & axiReq.wstrb[0];
	wire cntWrHi = wrFire & wHitCount & axiReq.wstrb[1];
	wire relWrLo = wrFire & wHitReload & axiReq.wstrb[0];
	wire relWrHi = wrFire & wHitReload & axiReq.wstrb[1];

	////////////////////////////////////////////////////////////////////////////
	// Configuration fields
	wire splitOn = modeCfg_reg[`SCPT_M_SPLIT];
	wire oeBit = modeCfg_reg[`SCPT_M_OE];
	wire lowRun = modeCfg_reg[`SCPT_M_LRUN];
	wire lowAutoClr = modeCfg_reg[`SCPT_M_LCLR];
	wire mainRun = ctrlCfg_reg[`SCPT_C_RUN];
	wire cpRl = ctrlCfg_reg[`SCPT_C_CPRL];
	wire accSel = mode1Cfg_reg[`SCPT_M1_ACC];
	wire ovfIgnore = mode1Cfg_reg[`SCPT_M1_IGN];
	wire [2:0] hiSrcSel = {mode1Cfg_reg[`SCPT_M1_CKS], modeCfg_reg[`SCPT_M_X12], ctrlCfg_reg[`SCPT_C_CT]};
	wire [1:0] loSrcSel = {mode1Cfg_reg[`SCPT_M1_LCHI], modeCfg_reg[`SCPT_M_LCLO]};
	wire [2:0] capSrcSel = mode1Cfg_reg[`SCPT_M1_SRC_HI:0];
	wire [2:0] modeCode = {mode1Cfg_reg[`SCPT_M1_MS1], cpRl, modeCfg_reg[`SCPT_M_MS0]};

	always_comb begin
		unique case (modeCode)
			3'b000: modeSel = SCPT_RELOAD;
			3'b001: modeSel = SCPT_RELOAD_EXT;
			3'b010: modeSel = SCPT_CAPTURE;
			3'b011: modeSel = SCPT_CAPTURE_ZERO;
			3'b100: modeSel = SCPT_PWM;
			default: modeSel = SCPT_RELOAD;
		endcase
	end

	wire isPwm = modeSel == SCPT_PWM;
	wire isZero = modeSel == SCPT_CAPTURE_ZERO;
	wire isCap = (modeSel == SCPT_CAPTURE) | isZero;
	wire isRel = (modeSel == SCPT_RELOAD) | (modeSel == SCPT_RELOAD_EXT);
	wire isRelExt = modeSel == SCPT_RELOAD_EXT;
	wire eightBit = splitOn | isPwm;
	wire clkOutMode = ~cpRl & oeBit & ~isPwm;

	////////////////////////////////////////////////////////////////////////////
	// Count sources
	wire [8:0] syncRise;
	wire [8:0] syncFall;
	scpt_sync_edge #(.W(9)) u_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.asyncIn({countPin, captureIn}),
		.rise(syncRise),
		.fall(syncFall)
	);

	wire div12Tick = div12_reg == `SCPT_PRESCALE_LAST;
	wire lowOvf;
	wire [7:0] hiSrc = {srcEvents.t1Ovf, srcEvents.ac1Event, srcEvents.t0Ovf, srcEvents.baudOvf,
		splitOn ? lowOvf : srcEvents.int1Event, 1'b1, syncFall[8], div12Tick};
	wire [3:0] loSrc = {srcEvents.int1Event, srcEvents.baudOvf, 1'b1, div12Tick};
	wire hiSrcTick = hiSrc[hiSrcSel];
	wire highTick = eightBit & mainRun & hiSrcTick;
	wire wideTick = ~eightBit & mainRun & hiSrcTick;
	wire lowTick = splitOn & ~isPwm & lowRun & loSrc[loSrcSel];
	wire [15:0] wideCount = {countHigh_reg, countLow_reg};
	wire highOvf = highTick & (countHigh_reg == 8'hff);
	assign lowOvf = lowTick & (countLow_reg == 8'hff);
	wire wideOvf = wideTick & (wideCount == 16'hffff);
	wire extEvent = (syncFall[capSrcSel] & ctrlCfg_reg[`SCPT_C_NEG])
		| (syncRise[capSrcSel] & modeCfg_reg[`SCPT_M_POS]);
	wire exportEvent = isPwm ? highOvf : (splitOn ? lowOvf : wideOvf);

	////////////////////////////////////////////////////////////////////////////
	// Flags and run control
	wire ovfSet = (wideOvf & ~clkOutMode) | highOvf;
	wire lowSet = lowOvf & ~clkOutMode;
	wire lowRunClr = splitOn & ~isPwm & lowAutoClr & ((isRel & highOvf) | (isCap & extEvent));
	wire ovfFlagNext = ovfSet | (ctrlWr ? wd[`SCPT_C_OVF] : ovfFlag_reg);
	wire extFlagNext = extEvent | (ctrlWr ? wd[`SCPT_C_EXT] : extFlag_reg);
	wire lowFlagNext = lowSet | ((ctrlWr & accSel) ? wd[`SCPT_C_B5] : lowFlag_reg);
	wire lowIeNext = (ctrlWr & accSel) ? wd[`SCPT_C_B4] : lowIe_reg;
	wire rxSelNext = (ctrlWr & ~accSel) ? wd[`SCPT_C_B5] : rxSel_reg;
	wire txSelNext = (ctrlWr & ~accSel) ? wd[`SCPT_C_B4] : txSel_reg;
	wire [7:0] modeWrVal = modeWr ? wd[7:0] : modeCfg_reg;
	wire [7:0] modeNext = {modeWrVal[7:4], modeWrVal[3] & ~lowRunClr, modeWrVal[2:0]};
	wire irqNext = (ovfFlag_reg & ~ovfIgnore) | extFlag_reg | (lowFlag_reg & lowIe_reg);
	wire pwmLevel = countHigh_reg >= countLow_reg;
	wire togNext = clkTog_reg ^ (exportEvent & ~cpRl & oeBit & ~isPwm);
	wire pinNext = oeBit & (isPwm ? pwmLevel : clkTog_reg);

	////////////////////////////////////////////////////////////////////////////
	// Counter datapath
	always_comb begin
		hiNext = countHigh_reg;
		loNext = countLow_reg;
		rhNext = reloadHigh_reg;
		rlNext = reloadLow_reg;
		if (isPwm) begin
			if (highOvf) begin
				hiNext = reloadHigh_reg;
				loNext = reloadLow_reg;
			end else if (highTick) begin
				hiNext = countHigh_reg + 8'h01;
			end
		end else if (splitOn) begin
			if (highOvf) begin
				hiNext = isCap ? 8'h00 : reloadHigh_reg;
			end else if (highTick) begin
				hiNext = countHigh_reg + 8'h01;
			end
			if (extEvent & isRelExt) begin
				hiNext = reloadHigh_reg;
			end
			if (extEvent & isCap) begin
				rhNext = countHigh_reg;
			end
			if (extEvent & isZero) begin
				hiNext = 8'h00;
			end
			if (lowOvf) begin
				loNext = reloadLow_reg;
			end else if (lowTick) begin
				loNext = countLow_reg + 8'h01;
			end
		end else begin
			if (wideOvf) begin
				{hiNext, loNext} = isCap ? 16'h0000 : {reloadHigh_reg, reloadLow_reg};
			end else if (wideTick) begin
				{hiNext, loNext} = wideCount + 16'h0001;
			end
			if (extEvent & isRelExt) begin
				{hiNext, loNext} = {reloadHigh_reg, reloadLow_reg};
			end
			if (extEvent & isCap) begin
				{rhNext, rlNext} = wideCount;
			end
			if (extEvent & isZero) begin
				{hiNext, loNext} = 16'h0000;
			end
		end
		loNext = cntWrLo ? wd[7:0] : loNext;
		hiNext = cntWrHi ? wd[15:8] : hiNext;
		rlNext = relWrLo ? wd[7:0] : rlNext;
		rhNext = relWrHi ? wd[15:8] : rhNext;
	end

	////////////////////////////////////////////////////////////////////////////
	// Read mux
	wire [7:0] ctrlRead = {ovfFlag_reg, extFlag_reg, accSel ? lowFlag_reg : rxSel_reg,
		accSel ? lowIe_reg : txSel_reg, ctrlCfg_reg};
	wire rHitCtrl = rdWord == `SCPT_OFF_CTRL >> 2;
	wire rHitMode = rdWord == `SCPT_OFF_MODE >> 2;
	wire rHitMode1 = rdWord == `SCPT_OFF_MODE1 >> 2;
	wire rHitCount = rdWord == `SCPT_OFF_COUNT >> 2;
	wire rHitReload = rdWord == `SCPT_OFF_RELOAD >> 2;
	wire rMapped = rHitCtrl | rHitMode | rHitMode1 | rHitCount | rHitReload;
	wire [31:0] rdMux = rHitCtrl ? {24'h000000, ctrlRead} : rHitMode ? {24'h000000, modeCfg_reg}
		: rHitMode1 ? {24'h000000, mode1Cfg_reg} : rHitCount ? {16'h0000, wideCount}
		: rHitReload ? {16'h0000, reloadHigh_reg, reloadLow_reg} : 32'h00000000;

	////////////////////////////////////////////////////////////////////////////
	// Bus channel state
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= `SCPT_RESP_OKAY;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= `SCPT_RESP_OKAY;
		end else begin
			bvalid_reg <= wrFire | (bvalid_reg & ~axiReq.bready);
			if (wrFire) begin
				bresp_reg <= wMapped ? `SCPT_RESP_OKAY : `SCPT_RESP_SLVERR;
			end
			rvalid_reg <= rdFire | (rvalid_reg & ~axiReq.rready);
			if (rdFire) begin
				rdata_reg <= rdMux;
				rresp_reg <= rMapped ? `SCPT_RESP_OKAY : `SCPT_RESP_SLVERR;
			end
		end
	end

	assign axiRsp = '{awready: wrFire, wready: wrFire, bvalid: bvalid_reg, bresp: bresp_reg,
		arready: ~rvalid_reg, rvalid: rvalid_reg, rdata: rdata_reg, rresp: rresp_reg};

	////////////////////////////////////////////////////////////////////////////
	// Control and flag state
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrlCfg_reg <= `SCPT_RST_NIBBLE;
			modeCfg_reg <= `SCPT_RST_BYTE;
			mode1Cfg_reg <= `SCPT_RST_BYTE;
			ovfFlag_reg <= 1'b0;
			extFlag_reg <= 1'b0;
			lowFlag_reg <= 1'b0;
			lowIe_reg <= 1'b0;
			rxSel_reg <= 1'b0;
			txSel_reg <= 1'b0;
		end else begin
			if (ctrlWr) begin
				ctrlCfg_reg <= wd[3:0];
			end
			modeCfg_reg <= modeNext;
			if (mode1Wr) begin
				mode1Cfg_reg <= wd[7:0];
			end
			ovfFlag_reg <= ovfFlagNext;
			extFlag_reg <= extFlagNext;
			lowFlag_reg <= lowFlagNext;
			lowIe_reg <= lowIeNext;
			rxSel_reg <= rxSelNext;
			txSel_reg <= txSelNext;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Counters and outputs
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			countLow_reg <= `SCPT_RST_BYTE;
			countHigh_reg <= `SCPT_RST_BYTE;
			reloadLow_reg <= `SCPT_RST_BYTE;
			reloadHigh_reg <= `SCPT_RST_BYTE;
			div12_reg <= `SCPT_RST_NIBBLE;
			clkTog_reg <= 1'b0;
			clockOutPin <= 1'b0;
			wideOverflowEvent <= 1'b0;
			timerIrq <= 1'b0;
		end else begin
			countLow_reg <= loNext;
			countHigh_reg <= hiNext;
			reloadLow_reg <= rlNext;
			reloadHigh_reg <= rhNext;
			div12_reg <= div12Tick ? `SCPT_RST_NIBBLE : div12_reg + 4'h1;
			clkTog_reg <= togNext;
			clockOutPin <= pinNext;
			wideOverflowEvent <= exportEvent;
			timerIrq <= irqNext;
		end
	end

	assign clockOutOe = oeBit;
	assign rxBaudSelect = rxSel_reg;
	assign txBaudSelect = txSel_reg;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	property p_auto_zero;
		(~eightBit & isZero & extEvent & ~cntWrLo & ~cntWrHi) |=> (wideCount == 16'h0000);
	endproperty
	a_auto_zero: assert property (p_auto_zero) else $error("count not zeroed by capture event");
	property p_capture;
		(~eightBit & isCap & extEvent & ~relWrLo & ~relWrHi)
			|=> ({reloadHigh_reg, reloadLow_reg} == $past(wideCount));
	endproperty
	a_capture: assert property (p_capture) else $error("count not captured");
	property p_low_run_clear;
		(splitOn & ~isPwm & lowAutoClr & isRel & highOvf) |=> !lowRun;
	endproperty
	a_low_run_clear: assert property (p_low_run_clear) else $error("low run bit survived overflow");
	property p_split_ovf;
		(splitOn & ~isPwm & highOvf) |=> ovfFlag_reg;
	endproperty
	a_split_ovf: assert property (p_split_ovf) else $error("overflow flag not set");
	property p_low_flag;
		(lowOvf & ~clkOutMode) |=> lowFlag_reg;
	endproperty
	a_low_flag: assert property (p_low_flag) else $error("low overflow flag not set");
	property p_flag_sticky;
		(ovfFlag_reg & ~ctrlWr) |=> ovfFlag_reg;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("overflow flag cleared by hardware");
	property p_ext_flag;
		extEvent |=> extFlag_reg;
	endproperty
	a_ext_flag: assert property (p_ext_flag) else $error("external flag missed an event");
	property p_pwm_load;
		(isPwm & highOvf & ~cntWrLo) |=> (countLow_reg == $past(reloadLow_reg));
	endproperty
	a_pwm_load: assert property (p_pwm_load) else $error("compare byte not loaded");
	property p_pin_gate;
		!oeBit |=> !clockOutPin;
	endproperty
	a_pin_gate: assert property (p_pin_gate) else $error("pin driven with output disabled");
	property p_toggle;
		(clkOutMode & wideOvf) |=> (clkTog_reg != $past(clkTog_reg)) ##1 (clockOutPin == $past(clkTog_reg));
	endproperty
	a_toggle: assert property (p_toggle) else $error("clock output did not toggle");
	property p_ignore;
		(ovfIgnore & ~extFlag_reg & ~(lowFlag_reg & lowIe_reg)) |=> !timerIrq;
	endproperty
	a_ignore: assert property (p_ignore) else $error("ignored overflow raised interrupt");
endmodule
`default_nettype wire

// File: sim/test_split_capture_pwm_timer.sv
// Self-checking testbench of the split capture/PWM timer
`timescale 1ns/1ps
`default_nettype none
`include "scpt_cfg.svh"
module test_split_capture_pwm_timer;
	import scpt_pkg::*;
	localparam logic [7:0] CTL = `SCPT_OFF_CTRL;
	localparam logic [7:0] MOD = `SCPT_OFF_MODE;
	localparam logic [7:0] MD1 = `SCPT_OFF_MODE1;
	localparam logic [7:0] CNT = `SCPT_OFF_COUNT;
	localparam logic [7:0] RLD = `SCPT_OFF_RELOAD;
	logic clk_sys;
	logic rst;
	scpt_axi_req_s axiReq;
	scpt_axi_rsp_s axiRsp;
	logic countPin;
	logic [7:0] captureIn;
	scpt_src_s srcEvents;
	logic clockOutPin;
	logic clockOutOe;
	logic wideOverflowEvent;
	logic timerIrq;
	logic rxBaudSelect;
	logic txBaudSelect;
	int num_errors;
	int n_tests;
	int hi;
	int rises;
	int ovs;
	logic [31:0] rd;
	logic [1:0] rsp;

	scpt_timer DUT (.clk_sys(clk_sys), .rst(rst), .axiReq(axiReq), .axiRsp(axiRsp), .countPin(countPin),
		.captureIn(captureIn), .srcEvents(srcEvents), .clockOutPin(clockOutPin), .clockOutOe(clockOutOe),
		.wideOverflowEvent(wideOverflowEvent), .timerIrq(timerIrq), .rxBaudSelect(rxBaudSelect),
		.txBaudSelect(txBaudSelect));

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

////////////////////////////////////////////////////////////////////////////////
	// Helpers
	task automatic check(input logic [31:0] g, input logic [31:0] e, input string m);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, m, g, e);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic resetDut;
		rst <= 1'b1;
		cyc(2);
		rst <= 1'b0;
		cyc(1);
	endtask

	task automatic axWrite(input logic [7:0] a, input logic [31:0] d);
		axiReq.awvalid <= 1'b1;
		axiReq.wvalid <= 1'b1;
		axiReq.awaddr <= a;
		axiReq.wdata <= d;
		axiReq.wstrb <= 4'hf;
		do @(posedge clk_sys); while (!(axiRsp.awready === 1'b1 && axiRsp.wready === 1'b1));
		axiReq.awvalid <= 1'b0;
		axiReq.wvalid <= 1'b0;
		do @(posedge clk_sys); while (axiRsp.bvalid !== 1'b1);
		rsp = axiRsp.bresp;
	endtask

	task automatic axRead(input logic [7:0] a);
		axiReq.arvalid <= 1'b1;
		axiReq.araddr <= a;
		do @(posedge clk_sys); while (axiRsp.arready !== 1'b1);
		axiReq.arvalid <= 1'b0;
		do @(posedge clk_sys); while (axiRsp.rvalid !== 1'b1);
		rd = axiRsp.rdata;
		rsp = axiRsp.rresp;
	endtask

	task automatic measure(input int n);
		logic prev;
		hi = 0;
		rises = 0;
		ovs = 0;
		prev = clockOutPin;
		repeat (n) begin
			@(posedge clk_sys);
			if (clockOutPin === 1'b1) hi++;
			if (clockOutPin === 1'b1 && prev === 1'b0) rises++;
			if (wideOverflowEvent === 1'b1) ovs++;
			prev = clockOutPin;
		end
	endtask

////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic tReset;
		for (int a = 0; a <= 16; a += 4) begin
			axRead(8'(a));
			check(rd, 32'h0, "reset value");
			check(32'(rsp), 32'h0, "read response");
		end
		axWrite(8'h14, 32'hff);
		check(32'(rsp), 32'(`SCPT_RESP_SLVERR), "unmapped write");
		axRead(8'h14);
		check({rsp, rd[29:0]}, {`SCPT_RESP_SLVERR, 30'h0}, "unmapped read");
		check(32'({clockOutPin, clockOutOe, timerIrq}), 32'h0, "idle outputs");
		$display("tReset done");
	endtask

	task automatic tSplitLow;
		resetDut;
		axWrite(CNT, 32'h10f0);
		axWrite(RLD, 32'h00a0);
		axWrite(MD1, 32'h20);
		axWrite(CTL, 32'h10);
		axWrite(MOD, 32'hc8);
		cyc(24);
		axWrite(MOD, 32'h80);
		axRead(CNT);
		check(32'(rd[15:8]), 32'h10, "high byte without main run");
		check(32'(rd[7:0] >= 8'ha0 && rd[7:0] < 8'hc0), 32'h1, "low byte reload");
		axRead(CTL);
		check(rd, 32'h30, "low flag set");
		check(32'(timerIrq), 32'h1, "low irq");
		cyc(20);
		axRead(CTL);
		check(rd, 32'h30, "low flag kept");
		axWrite(CTL, 32'h20);
		cyc(3);
		check(32'(timerIrq), 32'h0, "low irq disabled");
		axWrite(MD1, 32'h00);
		axWrite(CTL, 32'h20);
		cyc(3);
		check(32'({rxBaudSelect, txBaudSelect}), 32'h2, "baud selects");
		$display("tSplitLow done");
	endtask

	task automatic tLowSrc;
		logic [7:0] loB [4] = '{8'h03, 8'h30, 8'h0c, 8'h06};
		logic [7:0] hiB [4] = '{8'h05, 8'h40, 8'h0c, 8'h06};
		for (int c = 0; c < 4; c++) begin
			resetDut;
			axWrite(MD1, {24'h0, c[1], 7'h0});
			axWrite(MOD, {24'h0, 1'b1, c[0], 6'h08});
			for (int i = 0; i < 48; i++) begin
				srcEvents.baudOvf <= (i % 4 == 0);
				srcEvents.int1Event <= (i % 8 == 0);
				@(posedge clk_sys);
			end
			srcEvents <= '0;
			axWrite(MOD, 32'h80);
			axRead(CNT);
			check(32'(rd[7:0] >= loB[c] && rd[7:0] <= hiB[c]), 32'h1, "low source count");
		end
		$display("tLowSrc done");
	endtask

	task automatic tHighOvf;
		resetDut;
		axWrite(CNT, 32'hfc00);
		axWrite(RLD, 32'he000);
		axWrite(MD1, 32'h40);
		axWrite(MOD, 32'h9c);
		axWrite(CTL, 32'h04);
		measure(10);
		check(32'(ovs), 32'h0, "no export on high overflow");
		axRead(MOD);
		check(rd, 32'h94, "low run cleared");
		axRead(CTL);
		check(rd, 32'h84, "overflow flag");
		check(32'(timerIrq), 32'h0, "ignored irq");
		axRead(CNT);
		check(32'(rd[15:8] >= 8'he0), 32'h1, "high reload");
		axWrite(MD1, 32'h00);
		cyc(3);
		check(32'(timerIrq), 32'h1, "overflow irq");
		$display("tHighOvf done");
	endtask

	task automatic tCapture;
		resetDut;
		axWrite(CNT, 32'h1234);
		axWrite(MOD, 32'h11);
		axWrite(CTL, 32'h0d);
		cyc(4);
		captureIn <= 8'hfe;
		cyc(8);
		axRead(CTL);
		check(rd, 32'h4d, "external flag");
		check(32'(timerIrq), 32'h1, "external irq");
		axWrite(CTL, 32'h09);
		axRead(RLD);
		check(32'(rd[15:0] > 16'h1237 && rd[15:0] < 16'h1264), 32'h1, "captured count");
		axRead(CNT);
		check(32'(rd[15:0] < 16'h0030), 32'h1, "count zeroed");
		resetDut;
		axWrite(CNT, 32'h5000);
		axWrite(MOD, 32'hbd);
		axWrite(CTL, 32'h05);
		cyc(4);
		captureIn <= 8'hff;
		cyc(8);
		axRead(CTL);
		check(rd, 32'h45, "split external flag");
		axRead(MOD);
		check(rd, 32'hb5, "low run cleared by capture");
		axWrite(CTL, 32'h01);
		axRead(RLD);
		check(32'(rd[15:8] > 8'h53 && rd[15:8] < 8'h70), 32'h1, "high captured");
		axRead(CNT);
		check(32'(rd[15:8] < 8'h20), 32'h1, "high zeroed");
		$display("tCapture done");
	endtask

	task automatic tExtModes;
		resetDut;
		axWrite(CNT, 32'h4000);
		axWrite(RLD, 32'h9000);
		axWrite(MOD, 32'h91);
		axWrite(CTL, 32'h0c);
		cyc(4);
		captureIn <= 8'hfe;
		cyc(8);
		axWrite(CTL, 32'h08);
		axRead(CNT);
		check(32'(rd[15:8] >= 8'h90 && rd[15:8] < 8'hb0), 32'h1, "split external reload");
		resetDut;
		axWrite(CNT, 32'h2000);
		axWrite(MOD, 32'h30);
		axWrite(CTL, 32'h05);
		cyc(4);
		captureIn <= 8'hff;
		cyc(8);
		axRead(CTL);
		check(rd, 32'h45, "capture external flag");
		axWrite(CTL, 32'h01);
		axRead(CTL);
		check(rd, 32'h01, "external flag cleared by software");
		axRead(RLD);
		check(32'(rd[15:0] > 16'h2003 && rd[15:0] < 16'h2030), 32'h1, "plain capture");
		axRead(CNT);
		check(32'(rd[15:0] >= 16'h2008 && rd[15:0] < 16'h2040), 32'h1, "plain capture keeps count");
		$display("tExtModes done");
	endtask

	task automatic tPwm;
		resetDut;
		axWrite(CNT, 32'hf0f8);
		axWrite(RLD, 32'hf0f8);
		axWrite(MD1, 32'h08);
		axWrite(MOD, 32'h12);
		axWrite(CTL, 32'h04);
		cyc(40);
		measure(160);
		check(32'({hi[15:0], rises[7:0], ovs[7:0]}), 32'h00500a0a, "pwm 8 of 16");
		axRead(CTL);
		check(32'(rd[7]), 32'h1, "pwm overflow flag");
		axWrite(RLD, 32'hf0fc);
		cyc(40);
		measure(160);
		check(32'(hi), 32'h28, "pwm 4 of 16");
		axWrite(MOD, 32'h10);
		cyc(4);
		measure(32);
		check(32'({hi[7:0], 7'h0, clockOutOe}), 32'h0, "pwm gated");
		$display("tPwm done");
	endtask

	task automatic tClockOut;
		resetDut;
		axWrite(RLD, 32'hfff8);
		axWrite(CNT, 32'hfff8);
		axWrite(MOD, 32'h12);
		axWrite(CTL, 32'h04);
		cyc(40);
		check(32'(clockOutOe), 32'h1, "output enabled");
		measure(160);
		check(32'(hi), 32'h50, "half duty");
		check(32'(rises), 32'ha, "clock out period");
		check(32'(ovs), 32'h14, "overflow stream");
		axRead(CTL);
		check(rd, 32'h04, "no overflow flag");
		check(32'(timerIrq), 32'h0, "no irq");
		$display("tClockOut done");
	endtask

////////////////////////////////////////////////////////////////////////////////
	// Run control
	task automatic summarize;
		$display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		rst = 1'b1;
		axiReq = '0;
		axiReq.bready = 1'b1;
		axiReq.rready = 1'b1;
		countPin = 1'b0;
		captureIn = 8'hff;
		srcEvents = '0;
		num_errors = 0;
		n_tests = 0;
		cyc(12);
		rst <= 1'b0;
		cyc(1);
		tReset;
		tSplitLow;
		tLowSrc;
		tHighOvf;
		tCapture;
		tExtModes;
		tPwm;
		tClockOut;
		summarize;
	end

	initial begin
		#2000000;
		num_errors++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		summarize;
	end
endmodule
`default_nettype wire
